// File: verilog/flig_top.sv
// Top: limit registers, source configuration and interrupt output logic.
// Assumes a synchronous 16-bit register port from the serial front end.
// Overview of operation
// - Conversion-done enable set: assert output when configured set finishes.
// - Need 1 to 4 consecutive out-of-limit results, per 2-bit count.
// - Temperature crossings signalled only when temperature enable is one.
// - Z crossings signalled only while Z enable is one.
// - Y crossings signalled only while Y enable is one.
// - X crossings signalled only while X enable is one.
// - X upper code in bits 15-8, reset 0x7D.
// - X lower code in bits 7-0, reset 0x83.
// - Y upper code in bits 15-8, reset 0x7D.
// - Y lower code in bits 7-0, reset 0x83.
// - Z upper code in bits 15-8, reset 0x7D.
// - Z lower code in bits 7-0, reset 0x83.
// - Comparator mode: output is switch of enabled limits, no interrupts.
// - Hold mode keeps output until status read; else live.
`timescale 1ns/1ps
module flig_top (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic status_rd_in,
  input wire logic [3:0] result_vld_in,
  input wire logic [15:0] x_result_in,
  input wire logic [15:0] y_result_in,
  input wire logic [15:0] z_result_in,
  input wire logic [15:0] temp_result_in,
  input wire logic set_done_in,
  output logic [15:0] reg_rdata_out,
  output logic irq_out
);
  logic [15:0] x_field_limits_q;
  logic [15:0] y_field_limits_q;
  logic [15:0] z_field_limits_q;
  logic [15:0] temp_limits_q;
  logic [15:0] irq_source_config_q;
  logic [3:0] crossed;
  logic [3:0] outside;
  logic [3:0] src_en;
  logic [15:0] lim [flig_pkg::NUM_CH];
  logic [15:0] res [flig_pkg::NUM_CH];
  logic hold_q;
  logic done_q;
  logic live;
  logic fire;
  logic conv_done_irq_en;
  logic comp_mode;
  logic hold_mode;
  logic [1:0] crossing_count_sel;
  logic x_limit_irq_en;
  logic y_limit_irq_en;
  logic z_limit_irq_en;
  logic temp_limit_irq_en;
  logic [7:0] x_upper_limit;
  logic [7:0] x_lower_limit;
  logic [7:0] y_upper_limit;
  logic [7:0] y_lower_limit;
  logic [7:0] z_upper_limit;
  logic [7:0] z_lower_limit;
  logic [3:0] ch_vld;
  logic [15:0] rdata_d;
  logic irq_d;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = reg_wr_in && (a == b);
  endfunction : hit

  assign conv_done_irq_en = irq_source_config_q[flig_pkg::BIT_DONE_EN];
  assign comp_mode = irq_source_config_q[flig_pkg::BIT_COMP];
  assign hold_mode = irq_source_config_q[flig_pkg::BIT_HOLD];
  assign crossing_count_sel =
    irq_source_config_q[flig_pkg::CNT_HI:flig_pkg::CNT_LO];
  assign temp_limit_irq_en = irq_source_config_q[flig_pkg::BIT_T_EN];
  assign z_limit_irq_en = irq_source_config_q[flig_pkg::BIT_Z_EN];
  assign y_limit_irq_en = irq_source_config_q[flig_pkg::BIT_Y_EN];
  assign x_limit_irq_en = irq_source_config_q[flig_pkg::BIT_X_EN];
  assign src_en = {temp_limit_irq_en, z_limit_irq_en, y_limit_irq_en,
                   x_limit_irq_en};
  // Disabled channels see no results, so their runs stay frozen
  assign ch_vld = result_vld_in & src_en;

  // Limit code fields of each axis
  assign x_upper_limit = x_field_limits_q[flig_pkg::UP_HI:flig_pkg::UP_LO];
  assign x_lower_limit = x_field_limits_q[flig_pkg::LW_HI:flig_pkg::LW_LO];
  assign y_upper_limit = y_field_limits_q[flig_pkg::UP_HI:flig_pkg::UP_LO];
  assign y_lower_limit = y_field_limits_q[flig_pkg::LW_HI:flig_pkg::LW_LO];
  assign z_upper_limit = z_field_limits_q[flig_pkg::UP_HI:flig_pkg::UP_LO];
  assign z_lower_limit = z_field_limits_q[flig_pkg::LW_HI:flig_pkg::LW_LO];

  // X limits, upper byte then lower byte
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      x_field_limits_q <= flig_pkg::RST_AXIS_LIM;
    end else if (hit(reg_addr_in, flig_pkg::OFS_X_LIM)) begin
      x_field_limits_q <= reg_wdata_in;
    end
  end

  // Y limits, upper byte then lower byte
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      y_field_limits_q <= flig_pkg::RST_AXIS_LIM;
    end else if (hit(reg_addr_in, flig_pkg::OFS_Y_LIM)) begin
      y_field_limits_q <= reg_wdata_in;
    end
  end

  // Z limits, upper byte then lower byte
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      z_field_limits_q <= flig_pkg::RST_AXIS_LIM;
    end else if (hit(reg_addr_in, flig_pkg::OFS_Z_LIM)) begin
      z_field_limits_q <= reg_wdata_in;
    end
  end

  // Temperature limits
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      temp_limits_q <= flig_pkg::RST_TEMP_LIM;
    end else if (hit(reg_addr_in, flig_pkg::OFS_T_LIM)) begin
      temp_limits_q <= reg_wdata_in;
    end
  end

  // Source configuration; reserved bits stay zero
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_source_config_q <= flig_pkg::RST_IRQ_CFG;
    end else if (hit(reg_addr_in, flig_pkg::OFS_IRQ_CFG)) begin
      irq_source_config_q <= reg_wdata_in & flig_pkg::IRQ_CFG_MASK;
    end
  end

  // Read data selection; unmapped offsets read zero
  always_comb begin
    case (reg_addr_in)
      flig_pkg::OFS_IRQ_CFG: rdata_d = irq_source_config_q;
      flig_pkg::OFS_X_LIM: rdata_d = x_field_limits_q;
      flig_pkg::OFS_Y_LIM: rdata_d = y_field_limits_q;
      flig_pkg::OFS_Z_LIM: rdata_d = z_field_limits_q;
      flig_pkg::OFS_T_LIM: rdata_d = temp_limits_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // Registered read port
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end
  end

  assign lim[0] = {x_upper_limit, x_lower_limit};
  assign lim[1] = {y_upper_limit, y_lower_limit};
  assign lim[2] = {z_upper_limit, z_lower_limit};
  assign lim[3] = temp_limits_q;
  assign res[0] = x_result_in;
  assign res[1] = y_result_in;
  assign res[2] = z_result_in;
  assign res[3] = temp_result_in;

  // One checker per channel: X, Y, Z, temperature
  for (genvar i = 0; i < flig_pkg::NUM_CH; i++) begin : g_ch
    flig_channel u_ch (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .result_vld_in(ch_vld[i]),
      .result_in(res[i]),
      .limits_in(lim[i]),
      .count_sel_in(crossing_count_sel),
      .crossed_out(crossed[i]),
      .outside_out(outside[i])
    );
  end

  // Set-done event stands in hold mode until a status read
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
    end else if (set_done_in && conv_done_irq_en) begin
      done_q <= 1'b1;
    end else if (status_rd_in || !hold_mode) begin
      done_q <= 1'b0;
    end
  end

  assign live = |(crossed & src_en) || done_q;
  assign fire = live || (set_done_in && conv_done_irq_en);

  // Latched response: set wins over read clear
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_q <= 1'b0;
    end else if (fire && hold_mode && !comp_mode) begin
      hold_q <= 1'b1;
    end else if (status_rd_in || !hold_mode || comp_mode) begin
      hold_q <= 1'b0;
    end
  end

  // Next level: comparator switch or interrupt response
  always_comb begin
    if (comp_mode) begin
      irq_d = |(outside & src_en);
    end else begin
      irq_d = fire || hold_q;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
    end
  end
endmodule : flig_top

// File: verilog/flig_pkg.sv
// Package: register map, field layout and reset values of the limit block.
// Assumes a 16-bit register port driven by the serial front end.
package flig_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_CH = 4;
  localparam logic [3:0] OFS_IRQ_CFG = 4'h3;
  localparam logic [3:0] OFS_X_LIM = 4'h4;
  localparam logic [3:0] OFS_Y_LIM = 4'h5;
  localparam logic [3:0] OFS_Z_LIM = 4'h6;
  localparam logic [3:0] OFS_T_LIM = 4'h7;
  localparam logic [15:0] RST_AXIS_LIM = 16'h7D83;
  localparam logic [15:0] RST_TEMP_LIM = 16'h6732;
  localparam logic [15:0] RST_IRQ_CFG = 16'h0000;
  localparam logic [15:0] IRQ_CFG_MASK = 16'h313F;
  localparam int unsigned BIT_HOLD = 13;
  localparam int unsigned BIT_COMP = 12;
  localparam int unsigned BIT_DONE_EN = 8;
  localparam int unsigned CNT_HI = 5;
  localparam int unsigned CNT_LO = 4;
  localparam int unsigned BIT_T_EN = 3;
  localparam int unsigned BIT_Z_EN = 2;
  localparam int unsigned BIT_Y_EN = 1;
  localparam int unsigned BIT_X_EN = 0;
  localparam int unsigned UP_HI = 15;
  localparam int unsigned UP_LO = 8;
  localparam int unsigned LW_HI = 7;
  localparam int unsigned LW_LO = 0;
  localparam int unsigned RES_HI = 15;
  localparam int unsigned RES_LO = 8;
  localparam logic [2:0] RUN_ONE = 3'h1;
  localparam logic [2:0] RUN_MAX = 3'h4;
endpackage : flig_pkg

// File: verilog/flig_channel.sv
// One channel limit checker with consecutive out-of-limit run counter.
// Assumes result_vld_in pulses once per finished conversion of channel.
`timescale 1ns/1ps
module flig_channel (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic result_vld_in,
  input wire logic [15:0] result_in,
  input wire logic [15:0] limits_in,
  input wire logic [1:0] count_sel_in,
  output logic crossed_out,
  output logic outside_out
);
  logic [2:0] run_q;
  logic [2:0] run_d;
  logic [7:0] code;
  logic outside;
  logic crossed_q;

  assign code = result_in[flig_pkg::RES_HI:flig_pkg::RES_LO];
  // Signed compare of top result byte against the limit codes
  assign outside =
    ($signed(code) > $signed(limits_in[flig_pkg::UP_HI:flig_pkg::UP_LO])) ||
    ($signed(code) < $signed(limits_in[flig_pkg::LW_HI:flig_pkg::LW_LO]));

  always_comb begin
    run_d = run_q;
    if (result_vld_in) begin
      if (!outside) begin
        run_d = 3'h0;
      end else if (run_q != flig_pkg::RUN_MAX) begin
        run_d = run_q + flig_pkg::RUN_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= 3'h0;
    end else begin
      run_q <= run_d;
    end
  end

  // Run length reaches selected count 1..4
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      crossed_q <= 1'b0;
      outside_out <= 1'b0;
    end else if (result_vld_in) begin
      crossed_q <= run_d > {1'b0, count_sel_in};
      outside_out <= outside;
    end
  end

  assign crossed_out = crossed_q;
endmodule : flig_channel

// File: testbench/flig_checker.sv
// Checker: register and interrupt timing of the limit block.
// Assumes a bind onto flig_top; mirrors config and X limits.
`timescale 1ns/1ps
module flig_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic status_rd_in,
  input wire logic [3:0] result_vld_in,
  input wire logic [15:0] x_result_in,
  input wire logic set_done_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic irq_out
);
  logic [15:0] cfg_q;
  logic [15:0] xl_q;
  logic x_out;
  assign x_out = $signed(x_result_in[15:8]) > $signed(xl_q[15:8]) ||
    $signed(x_result_in[15:8]) < $signed(xl_q[7:0]);
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= 16'h0000;
      xl_q <= 16'h7D83;
    end else if (reg_wr_in && reg_addr_in == 4'h3) begin
      cfg_q <= reg_wdata_in & 16'h313F;
    end else if (reg_wr_in && reg_addr_in == 4'h4) begin
      xl_q <= reg_wdata_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_wr; reg_wr_in && reg_addr_in == 4'h4; endsequence
  sequence s_rd; reg_rd_in && reg_addr_in == 4'h4; endsequence
  property p_wr_rd;
    s_wr ##2 s_rd |=> reg_rdata_out == $past(reg_wdata_in, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("limit readback");
  property p_done; set_done_in && cfg_q[8] && !cfg_q[12] |=> irq_out;
  endproperty
  a_done: assert property (p_done) else $error("done irq");
  property p_x_cross;
    result_vld_in[0] && cfg_q[5:0] == 6'h01 && !cfg_q[12] && x_out
      |-> ##2 irq_out;
  endproperty
  a_x_cross: assert property (p_x_cross) else $error("x irq");
  property p_x_clear;
    result_vld_in[0] && cfg_q == 16'h0001 && !x_out |-> ##2 !irq_out;
  endproperty
  a_x_clear: assert property (p_x_clear) else $error("x clr");
  property p_hold;
    cfg_q[13] && !cfg_q[12] && irq_out && !status_rd_in && !reg_wr_in
      && !$past(status_rd_in) && !$past(reg_wr_in) |=> irq_out;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_quiet;
    cfg_q[8] == 1'b0 && cfg_q[3:0] == 4'h0 && $stable(cfg_q) && !irq_out
      |=> !irq_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_comp;
    cfg_q[12] && cfg_q[3:0] == 4'h1 && result_vld_in[0]
      |-> ##2 irq_out == $past(x_out, 2);
  endproperty
  a_comp: assert property (p_comp) else $error("comparator");
  property p_rise;
    $rose(irq_out) |-> $past(set_done_in) || $past(result_vld_in, 2) != 0
      || $past(reg_wr_in) || $past(reg_wr_in, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("stray irq");
endmodule : flig_checker

// File: testbench/flig_host_model.sv
// Host model: microcontroller side of the register port.
// Assumes tasks start and end at a falling clock edge.
`timescale 1ns/1ps
module flig_host_model (
  input wire logic sys_clk_in,
  input wire logic [15:0] reg_rdata_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [3:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic status_rd_out
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 4'h0;
    reg_wdata_out = 16'h0000;
    status_rd_out = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
    @(negedge sys_clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_out = 1'b0;
    d = reg_rdata_in;
    @(negedge sys_clk_in);
  endtask : rd
  task automatic sts();
    status_rd_out = 1'b1;
    @(negedge sys_clk_in);
    status_rd_out = 1'b0;
    @(negedge sys_clk_in);
  endtask : sts
endmodule : flig_host_model

// File: testbench/field_limit_irq_generator_tb.sv
// Testbench: drives results and host accesses, judges irq_out.
// Assumes flig_top, flig_host_model and flig_checker compiled.
`timescale 1ns/1ps
module field_limit_irq_generator_tb;
  logic sys_clk_in, rst_in, set_done_in, irq_out, wr_s, rd_s, st_s;
  logic [3:0] vld, addr;
  logic [15:0] wdata, rdata, rv;
  logic [15:0] res [4];
  int fail_count = 0;
  int samples_checked = 0;
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  flig_host_model flig_host_model_inst (.sys_clk_in, .reg_rdata_in(rdata),
    .reg_wr_out(wr_s), .reg_rd_out(rd_s), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .status_rd_out(st_s));
  flig_top flig_top_inst (.sys_clk_in, .rst_in, .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .status_rd_in(st_s), .result_vld_in(vld), .x_result_in(res[0]),
    .y_result_in(res[1]), .z_result_in(res[2]), .temp_result_in(res[3]),
    .set_done_in, .reg_rdata_out(rdata), .irq_out);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t reg %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_irq(input logic e);
    samples_checked++;
    if (irq_out !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t irq exp %b", $time, e);
    end
  endtask : chk_irq
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    flig_host_model_inst.wr(a, d);
  endtask : wr
  task automatic hit(input int ch, input logic [7:0] v);
    res[ch] = {v, 8'h00};
    vld[ch] = 1'b1;
    @(negedge sys_clk_in);
    vld[ch] = 1'b0;
    res[ch] = {~v, 8'hFF};
    @(negedge sys_clk_in);
  endtask : hit
  task automatic t_regs();
    for (int a = 4; a < 7; a++) begin
      flig_host_model_inst.rd(4'(a), rv);
      chk(rv, 16'h7D83);
    end
    wr(4'h4, 16'h1280);
    flig_host_model_inst.rd(4'h4, rv);
    chk(rv, 16'h1280);
    wr(4'h4, 16'h7D83);
    flig_host_model_inst.rd(4'h7, rv);
    chk(rv, 16'h6732);
    wr(4'h3, 16'hFFFF);
    flig_host_model_inst.rd(4'h3, rv);
    chk(rv, 16'h313F);
    wr(4'h3, 16'h0000);
  endtask : t_regs
  task automatic t_count();
    for (int c = 0; c < 4; c++) begin
      wr(4'h3, 16'h0001 | 16'(c << 4));
      repeat (c) hit(0, 8'h7F);
      chk_irq(1'b0);
      hit(0, 8'h90);
      repeat (c) hit(0, 8'h81);
      chk_irq(1'b0);
      hit(0, 8'h81);
      chk_irq(1'b1);
      hit(0, 8'h90);
      chk_irq(1'b0);
    end
  endtask : t_count
  task automatic t_axes();
    for (int i = 0; i < 4; i++) begin
      wr(4'h3, 16'(1 << i));
      hit((i + 1) % 4, 8'h7F);
      chk_irq(1'b0);
      hit(i, 8'h7F);
      chk_irq(1'b1);
      hit(i, 8'h40);
    end
  endtask : t_axes
  task automatic t_done(input logic en);
    wr(4'h3, {7'h00, en, 8'h00});
    set_done_in = 1'b1;
    @(negedge sys_clk_in);
    set_done_in = 1'b0;
    chk_irq(en);
    repeat (3) @(negedge sys_clk_in);
  endtask : t_done
  task automatic t_hold();
    wr(4'h3, 16'h2001);
    hit(0, 8'h7F);
    hit(0, 8'h40);
    chk_irq(1'b1);
    flig_host_model_inst.sts();
    chk_irq(1'b0);
  endtask : t_hold
  task automatic t_comp();
    wr(4'h3, 16'h1001);
    hit(0, 8'h7F);
    chk_irq(1'b1);
    hit(0, 8'h40);
    chk_irq(1'b0);
  endtask : t_comp
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    rst_in = 1'b1;
    set_done_in = 1'b0;
    vld = 4'h0;
    foreach (res[k]) res[k] = 16'h0000;
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_regs();
    t_count();
    t_axes();
    t_done(1'b1);
    t_done(1'b0);
    t_hold();
    t_comp();
    summarize();
  end
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule : field_limit_irq_generator_tb
bind flig_top flig_checker flig_checker_inst (.sys_clk_in, .rst_in,
  .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .status_rd_in,
  .result_vld_in, .x_result_in, .set_done_in, .reg_rdata_out, .irq_out);
